//--- core/svd_consts.svh
/*
  offsets, field positions and reset values of the supply level detector.
  assumes inclusion by bare name from the top module only.
*/
`ifndef SVD_CONSTS_SVH
`define SVD_CONSTS_SVH

// register byte offsets
`define SVD_OFF_CTRL      5'h00
`define SVD_OFF_CTRL_CLR  5'h04
`define SVD_OFF_CTRL_SET  5'h08
`define SVD_OFF_CTRL_INV  5'h0c
`define SVD_OFF_IRQ_STS   5'h10
`define SVD_OFF_IRQ_MASK  5'h14

// control register fields
`define SVD_BIT_EN        15
`define SVD_BIT_STOP_IN_IDLE      13
`define SVD_BIT_DIR       11
`define SVD_BIT_BGST      10
`define SVD_BIT_REFST     9
`define SVD_BIT_EVT       8
`define SVD_LVL_MSB       3
`define SVD_LVL_LSB       0
`define SVD_CTRL_WMASK    32'h0000_a80f

// trip level codes
`define SVD_LVL_EXT       4'hf
`define SVD_LVL_MIN_OK    4'h5

// interrupt status fields
`define SVD_IRQ_EVT       0
`define SVD_IRQ_REF       1
`define SVD_IRQ_WMASK     32'h0000_0003

// reset values
`define SVD_CTRL_RST      32'h0000_0000
`define SVD_IRQ_RST       32'h0000_0000

`endif

//--- core/svd_pkg.sv
/*
  types of the supply level detector.
  assumes svd_consts.svh beside it.
*/
package svd_pkg;
  typedef struct packed {
    logic       en;
    logic       stop_in_idle;
    logic       dir;
    logic [3:0] level;
  } svd_ctrl_s;

  typedef enum logic [1:0] {
    SVD_LVL_RESERVED,
    SVD_LVL_SUPPLY,
    SVD_LVL_EXTERNAL
  } svd_lvl_e;
endpackage

//--- core/svd_top.sv
/*
  supply level detector control: apb slave with control register and its
  clear/set/invert aliases, sticky interrupt status and mask, comparator
  synchroniser and event gating.
  assumes an analog comparator that drives asynchronous compare levels and
  stability levels, and an idle indication synchronous to pclk.
*/
// Overview of operation
// RULE1: bit 15 of the control register enables the detector when set.
// RULE2: bit 13 set halts the detector while the device idles.
// RULE3: bit 11 picks the event: one for at or above trip, zero for at or below.
// RULE4: read-only bit 10 shows that the band gap is stable.
// RULE5: read-only bit 9 shows reference stability and only then may events flag.
// RULE6: software keeps the interrupt masked until the reference is stable.
// RULE7: read-only bit 8 is one while a detection event is active.
// RULE8: bits 10 to 8 are hardware owned, ignore writes, and all fields reset to 0.
// RULE9: trip code 1111 compares the external sense pin with the band gap.
// RULE10: codes 1110 down to 0101 pick supply trip points from lowest to highest.
// RULE11: software never programs the reserved codes 0100 to 0000.
// RULE12: bits 31-16, 14, 12 and 7-4 read zero and ignore writes.
// RULE13: a crossing in the chosen direction sets the detector interrupt flag.
// RULE14: offsets 0x4, 0x8 and 0xc clear, set and invert writable control bits.
// RULE15: the comparator output is synchronised and the event follows it.
// RULE16: while disabled or stopped in idle, event and flag stay inactive.
`timescale 1ns/10ps
`include "svd_consts.svh"

module svd_top #(
  parameter int ADDR_W      = 8,
  parameter int SYNC_STAGES = 2
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // analog comparator side
  input  wire logic              cmp_ge_async,
  input  wire logic              cmp_le_async,
  input  wire logic              bandgap_ok_async,
  input  wire logic              reference_ok_async,
  output logic                   detector_on,
  output logic                   external_sense_sel,
  output logic      [3:0]        trip_code,
  // system
  input  wire logic              idle_mode,
  output logic                   irq
);

  // the decode slices paddr above bit 4, so at least one upper bit must exist
  if (ADDR_W < 6 || ADDR_W > 32) begin
    $error("svd_top: ADDR_W must be 6..32");
  end
  if (SYNC_STAGES < 2) begin
    $error("svd_top: SYNC_STAGES must be at least 2");
  end

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic svd_pkg::svd_lvl_e lvl_class(input logic [3:0] code);
    if (code == `SVD_LVL_EXT)
      lvl_class = svd_pkg::SVD_LVL_EXTERNAL;
    else if (code >= `SVD_LVL_MIN_OK)
      lvl_class = svd_pkg::SVD_LVL_SUPPLY;
    else
      lvl_class = svd_pkg::SVD_LVL_RESERVED;
  endfunction

  svd_pkg::svd_ctrl_s ctrl_q;
  logic [31:0]        ctrl_word;
  logic [31:0]        wmask;
  logic [31:0]        irq_sts_q;
  logic [31:0]        irq_mask_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               on_q;
  logic               ext_q;
  logic [3:0]         code_q;
  logic               irq_q;
  logic               bg_q;
  logic               ref_q;
  logic               evt_q;
  logic               evt_d;
  logic               setup;
  logic               access;
  logic               hit_ctrl;
  logic               hit_clr;
  logic               hit_set;
  logic               hit_inv;
  logic               hit_sts;
  logic               hit_mask;
  logic               mapped;
  logic [4:0]         off;
  logic [31:0]        sts_set;
  logic [SYNC_STAGES-1:0] ge_sync_q;
  logic [SYNC_STAGES-1:0] le_sync_q;
  logic [SYNC_STAGES-1:0] bg_sync_q;
  logic [SYNC_STAGES-1:0] ref_sync_q;

  // bus decode; upper address bits must be zero for a hit
  assign setup    = psel & ~penable;
  assign access   = psel & penable & pready_q;
  assign off      = paddr[4:0];
  assign mapped   = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:5] == '0)
                    && (off <= `SVD_OFF_IRQ_MASK);
  assign hit_ctrl = mapped && (off == `SVD_OFF_CTRL);
  assign hit_clr  = mapped && (off == `SVD_OFF_CTRL_CLR);
  assign hit_set  = mapped && (off == `SVD_OFF_CTRL_SET);
  assign hit_inv  = mapped && (off == `SVD_OFF_CTRL_INV);
  assign hit_sts  = mapped && (off == `SVD_OFF_IRQ_STS);
  assign hit_mask = mapped && (off == `SVD_OFF_IRQ_MASK);
  assign wmask    = strb_mask(pstrb) & `SVD_CTRL_WMASK; // RULE8 RULE12

  // unimplemented bits stay zero because only declared fields are placed
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`SVD_BIT_EN] = ctrl_q.en; // RULE1
    ctrl_word[`SVD_BIT_STOP_IN_IDLE] = ctrl_q.stop_in_idle; // RULE2
    ctrl_word[`SVD_BIT_DIR] = ctrl_q.dir; // RULE3
    ctrl_word[`SVD_BIT_BGST] = bg_q; // RULE4
    ctrl_word[`SVD_BIT_REFST] = ref_q; // RULE5
    ctrl_word[`SVD_BIT_EVT] = evt_q; // RULE7
    ctrl_word[`SVD_LVL_MSB:`SVD_LVL_LSB] = ctrl_q.level;
  end

  // control register and its aliases, written on the access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= svd_pkg::svd_ctrl_s'(7'h00); // RULE8
    end else if (access && pwrite) begin
      if (hit_ctrl) begin
        ctrl_q.en <= wmask[`SVD_BIT_EN] ? pwdata[`SVD_BIT_EN] : ctrl_q.en;
        ctrl_q.stop_in_idle <= wmask[`SVD_BIT_STOP_IN_IDLE] ? pwdata[`SVD_BIT_STOP_IN_IDLE] : ctrl_q.stop_in_idle;
        ctrl_q.dir <= wmask[`SVD_BIT_DIR] ? pwdata[`SVD_BIT_DIR] : ctrl_q.dir;
        if (wmask[0])
          ctrl_q.level <= pwdata[3:0];
      end else if (hit_clr || hit_set || hit_inv) begin // RULE14
        if (wmask[`SVD_BIT_EN] && pwdata[`SVD_BIT_EN])
          ctrl_q.en <= hit_set | (hit_inv & ~ctrl_q.en);
        if (wmask[`SVD_BIT_STOP_IN_IDLE] && pwdata[`SVD_BIT_STOP_IN_IDLE])
          ctrl_q.stop_in_idle <= hit_set | (hit_inv & ~ctrl_q.stop_in_idle);
        if (wmask[`SVD_BIT_DIR] && pwdata[`SVD_BIT_DIR])
          ctrl_q.dir <= hit_set | (hit_inv & ~ctrl_q.dir);
        if (wmask[0])
          ctrl_q.level <= hit_set ? (ctrl_q.level | pwdata[3:0]) :
                          hit_inv ? (ctrl_q.level ^ pwdata[3:0]) :
                                    (ctrl_q.level & ~pwdata[3:0]);
      end
    end
  end

  // apb answer: no wait state; prdata and pready come from flops loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_q <= (hit_ctrl | hit_clr | hit_set | hit_inv) ? ctrl_word :
                    hit_sts  ? irq_sts_q :
                    hit_mask ? irq_mask_q : 32'h0000_0000;
      end else if (setup) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // synchronisers: stage 0 feeds only stage 1; flushed while the analog side is
  // unpowered, so its wander cannot reach the flags in the cycle after power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ge_sync_q  <= '0;
      le_sync_q  <= '0;
      bg_sync_q  <= '0;
      ref_sync_q <= '0;
    end else if (!on_q) begin
      ge_sync_q  <= '0;
      le_sync_q  <= '0;
      bg_sync_q  <= '0;
      ref_sync_q <= '0;
    end else begin
      ge_sync_q  <= {ge_sync_q[SYNC_STAGES-2:0], cmp_ge_async}; // RULE15
      le_sync_q  <= {le_sync_q[SYNC_STAGES-2:0], cmp_le_async}; // RULE15
      bg_sync_q  <= {bg_sync_q[SYNC_STAGES-2:0], bandgap_ok_async};
      ref_sync_q <= {ref_sync_q[SYNC_STAGES-2:0], reference_ok_async};
    end
  end

  // analog steering; a reserved code keeps the detector powered down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q   <= 1'b0;
      ext_q  <= 1'b0;
      code_q <= 4'h0;
    end else begin
      on_q <= ctrl_q.en // RULE1
              & ~(idle_mode & ctrl_q.stop_in_idle) // RULE2
              & (lvl_class(ctrl_q.level) != svd_pkg::SVD_LVL_RESERVED); // RULE11
      ext_q  <= lvl_class(ctrl_q.level) == svd_pkg::SVD_LVL_EXTERNAL; // RULE9
      code_q <= ctrl_q.level; // RULE10
    end
  end

  // hardware owned flags; cleared while the detector is off
  assign evt_d = on_q & ref_q & (ctrl_q.dir ? ge_sync_q[SYNC_STAGES-1] // RULE3
                                            : le_sync_q[SYNC_STAGES-1]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bg_q  <= 1'b0; // RULE8
      ref_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      bg_q  <= on_q & bg_sync_q[SYNC_STAGES-1]; // RULE4
      ref_q <= on_q & ref_sync_q[SYNC_STAGES-1]; // RULE5
      evt_q <= evt_d; // RULE7 RULE15 RULE16
    end
  end

  // sticky status: a new event beats a simultaneous write-one clear
  always_comb begin
    sts_set = 32'h0000_0000;
    sts_set[`SVD_IRQ_EVT] = evt_d & ~evt_q; // RULE13
    sts_set[`SVD_IRQ_REF] = on_q & ref_sync_q[SYNC_STAGES-1] & ~ref_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= `SVD_IRQ_RST;
    end else if (access && pwrite && hit_sts) begin
      irq_sts_q <= (irq_sts_q & ~(pwdata & strb_mask(pstrb))) | sts_set;
    end else begin
      irq_sts_q <= irq_sts_q | sts_set; // RULE13
    end
  end

  // mask resets closed, so nothing fires before software opens it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= `SVD_IRQ_RST;
    end else if (access && pwrite && hit_mask) begin
      irq_mask_q <= ((irq_mask_q & ~strb_mask(pstrb)) | (pwdata & strb_mask(pstrb)))
                    & `SVD_IRQ_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_sts_q & irq_mask_q); // RULE6
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign detector_on        = on_q;
  assign external_sense_sel = ext_q;
  assign trip_code          = code_q;
  assign irq                = irq_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence set_write_s;
    setup && pwrite && hit_set && pstrb == 4'hf ##1 access;
  endsequence

  sequence crossing_s;
    (on_q && ref_q && ctrl_q.dir && cmp_ge_async) [*4];
  endsequence

  sequence clr_write_s;
    setup && pwrite && hit_clr && pstrb == 4'hf ##1 access;
  endsequence

  sequence inv_write_s;
    setup && pwrite && hit_inv && pstrb == 4'hf ##1 access;
  endsequence

  sequence bad_write_s;
    setup && pwrite && !mapped ##1 access;
  endsequence

  sequence quiet_s;
    (on_q && ref_q && ctrl_q.dir && !cmp_ge_async) [*4];
  endsequence

  enable_gate_a: assert property (on_q |-> $past(ctrl_q.en)) // RULE1
    else $error("detector on without enable");
  idle_stop_a: assert property ($past(idle_mode && ctrl_q.stop_in_idle) |-> !on_q) // RULE2
    else $error("detector running in idle with stop set");
  set_alias_a: assert property (set_write_s |=> ctrl_q.en == ($past(ctrl_q.en) // RULE14
      || $past(pwdata[`SVD_BIT_EN])))
    else $error("set alias did not set enable");
  ref_gate_a: assert property (!ref_q |=> !evt_q) // RULE5
    else $error("event flagged with unstable reference");
  off_quiet_a: assert property (!on_q |=> !evt_q && !bg_q) // RULE16
    else $error("flags active while detector off");
  event_follow_a: assert property (crossing_s |-> ##[0:3] evt_q) // RULE15
    else $error("event did not follow comparator");
  sticky_flag_a: assert property ($rose(evt_q) |-> irq_sts_q[`SVD_IRQ_EVT]) // RULE13
    else $error("event did not set interrupt status");
  irq_level_a: assert property (irq_q == $past(|(irq_sts_q & irq_mask_q))) // RULE6
    else $error("interrupt output disagrees with status and mask");
  unused_zero_a: assert property (pready_q |-> prdata_q[31:16] == 16'h0000 // RULE12
      && prdata_q[14] == 1'b0 && prdata_q[12] == 1'b0)
    else $error("unimplemented bits read nonzero");
  ext_select_a: assert property (ext_q == $past(ctrl_q.level == `SVD_LVL_EXT)) // RULE9
    else $error("external select wrong");
  clr_alias_a: assert property (clr_write_s |=> ctrl_q.en == ($past(ctrl_q.en) // RULE14
      && !$past(pwdata[`SVD_BIT_EN])))
    else $error("clear alias did not clear enable");
  inv_alias_a: assert property (inv_write_s |=> ctrl_q.dir == ($past(ctrl_q.dir) // RULE14
      ^ $past(pwdata[`SVD_BIT_DIR])))
    else $error("invert alias did not toggle direction");
  bad_write_a: assert property (bad_write_s |=> $stable(ctrl_q) && $stable(irq_mask_q)) // RULE12
    else $error("unmapped write changed a register");
  event_clear_a: assert property (quiet_s |-> ##[0:3] !evt_q) // RULE15
    else $error("event did not clear with comparator");
  sts_clear_a: assert property (access && pwrite && hit_sts && pstrb[0] // RULE13
      && pwdata[`SVD_IRQ_EVT] && !sts_set[`SVD_IRQ_EVT] |=> !irq_sts_q[`SVD_IRQ_EVT])
    else $error("write one did not clear event status");
  status_hold_a: assert property (irq_sts_q[`SVD_IRQ_EVT] // RULE13
      && !(access && pwrite && hit_sts) |=> irq_sts_q[`SVD_IRQ_EVT])
    else $error("event status dropped without a clear");
  reserved_off_a: assert property ($past(ctrl_q.level < `SVD_LVL_MIN_OK) |-> !on_q) // RULE11
    else $error("detector powered with a reserved trip code");
  unused_low_a: assert property (pready_q |-> prdata_q[7:4] == 4'h0) // RULE12
    else $error("unimplemented low bits read nonzero");
  pready_pulse_a: assert property (pready_q |=> !pready_q)
    else $error("ready held longer than one access cycle");

endmodule

//--- bench/svd_cmp_model.sv
/*
  comparator and stability model of the level detector's analog side.
  assumes the bench drives vmon as a coarse voltage step.
*/
`timescale 1ns/10ps
module svd_cmp_model #(
  parameter int STAB = 6
) (
  // controls from the block
  input  wire logic       pclk,
  input  wire logic       detector_on,
  input  wire logic       external_sense_sel,
  input  wire logic [3:0] trip_code,
  // monitored voltage step
  input  wire logic [3:0] vmon,
  // analog levels
  output logic            cmp_ge_async,
  output logic            cmp_le_async,
  output logic            bandgap_ok_async,
  output logic            reference_ok_async
);
  logic [3:0] thr;
  logic       tog = 1'b0;
  int         cnt = 0;
  // higher code means lower trip; the external pin sits at the band gap step
  assign thr = external_sense_sel ? 4'h8 : 4'hf - trip_code;
  always @(posedge pclk) begin
    tog <= ~tog;
    cnt <= detector_on ? ((cnt < 2 * STAB) ? cnt + 1 : cnt) : 0;
  end
  // unpowered outputs wander, so the block has to gate them itself
  always_comb begin
    if (detector_on) begin
      cmp_ge_async       = vmon >= thr;
      cmp_le_async       = vmon <= thr;
      bandgap_ok_async   = cnt >= STAB;
      reference_ok_async = cnt >= 2 * STAB;
    end else begin
      cmp_ge_async       = tog;
      cmp_le_async       = tog;
      bandgap_ok_async   = tog;
      reference_ok_async = tog;
    end
  end
endmodule

//--- bench/tb_top.sv
/*
  self-checking bench of the supply level detector control.
  assumes svd_top and the comparator model; apb master with no wait limit.
*/
`timescale 1ns/10ps
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        idle_mode = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  vmon = 4'h0;
  logic [31:0] seed = 32'h2a535bcc;
  logic [31:0] prdata, q;
  logic [3:0]  tcode, c, quiet;
  logic        pready, pslverr, ge, le, bg, rf, on, ext, irq, e;
  int          miscompares = 0;
  int          compares = 0;

  always #2 pclk = ~pclk;

  svd_top #(.ADDR_W(8), .SYNC_STAGES(2)) svd_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_ge_async(ge), .cmp_le_async(le), .bandgap_ok_async(bg),
    .reference_ok_async(rf), .detector_on(on), .external_sense_sel(ext),
    .trip_code(tcode), .idle_mode(idle_mode), .irq(irq));

  svd_cmp_model #(.STAB(6)) svd_cmp_model_inst (
    .pclk(pclk), .detector_on(on), .external_sense_sel(ext), .trip_code(tcode),
    .vmon(vmon), .cmp_ge_async(ge), .cmp_le_async(le), .bandgap_ok_async(bg),
    .reference_ok_async(rf));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask

  function automatic logic [31:0] ctl(input logic d, input logic [3:0] k, input logic [2:0] f);
    return {16'h0000, 4'h8, d, f, 4'h0, k};
  endfunction

  function automatic logic [3:0] thr(input logic [3:0] k);
    return 4'hf - k;
  endfunction

  function automatic logic [3:0] rnd_code();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return 4'h5 + 4'(seed[15:0] % 10);
  endfunction

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdc("reset", 8'(i * 4), 32'h0);
    apb(1'b1, 8'h00, 32'hffff7fff);
    rdc("wmask", 8'h00, 32'h0000280f);
    apb(1'b1, 8'h04, 32'hffffffff);
    apb(1'b1, 8'h0c, 32'h0000880f);
    rdc("alias", 8'h08, 32'h0000880f);
    chk("ext", ext, 1);
    chk("on", on, 1);
    apb(1'b1, 8'h0c, 32'h00008000);
    repeat (2) @(posedge pclk);
    chk("off", on, 0);
    apb(1'b1, 8'h00, 32'h00008804);
    repeat (2) @(posedge pclk);
    chk("rsvd", {tcode, 3'b000, on}, 32'h40);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    apb(1'b1, 8'h18, 32'hffffffff);
    chk("unmapped write", {q[30:0], e}, 32'h1);
    rdc("kept", 8'h00, 32'h00008804);
    $display("test registers done");
    for (int d = 0; d < 2; d++) begin
      c = rnd_code();
      quiet = d[0] ? 4'h0 : 4'hf;
      vmon <= quiet;
      apb(1'b1, 8'h00, ctl(d[0], c, 3'b000));
      rdc("early", 8'h00, ctl(d[0], c, 3'b000));
      repeat (30) @(posedge pclk);
      rdc("stable", 8'h00, ctl(d[0], c, 3'b110));
      apb(1'b1, 8'h10, 32'h3);
      apb(1'b1, 8'h14, 32'h1);
      vmon <= thr(c);
      repeat (5) @(posedge pclk);
      rdc("event", 8'h00, ctl(d[0], c, 3'b111));
      chk("irq", irq, 1);
      rdc("status", 8'h10, 32'h1);
      vmon <= quiet;
      repeat (5) @(posedge pclk);
      rdc("ended", 8'h00, ctl(d[0], c, 3'b110));
      apb(1'b1, 8'h10, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq clear", irq, 0);
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
    end
    $display("test event done");
    apb(1'b1, 8'h00, ctl(1'b1, 4'h5, 3'b000));
    repeat (30) @(posedge pclk);
    for (int k = 5; k < 15; k++) begin
      apb(1'b1, 8'h00, ctl(1'b1, 4'(k), 3'b000));
      vmon <= thr(4'(k)) - 4'h1;
      repeat (5) @(posedge pclk);
      rdc("below", 8'h00, ctl(1'b1, 4'(k), 3'b110));
      vmon <= thr(4'(k));
      repeat (5) @(posedge pclk);
      rdc("at", 8'h00, ctl(1'b1, 4'(k), 3'b111));
    end
    chk("masked", irq, 0);
    $display("test sweep done");
    apb(1'b1, 8'h08, 32'h00002000);
    idle_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("idle off", on, 0);
    rdc("idle", 8'h00, ctl(1'b1, 4'he, 3'b000) | 32'h2000);
    apb(1'b1, 8'h04, 32'h00002000);
    repeat (30) @(posedge pclk);
    rdc("idle run", 8'h00, ctl(1'b1, 4'he, 3'b111));
    idle_mode <= 1'b0;
    $display("test idle done");
    close_out();
  end

  // about five times the expected run length of some 500 cycles
  initial begin
    #10000;
    miscompares++;
    close_out();
  end
endmodule
